// ### core/sink_fifo_pkg.sv
//------------------------------------------------------------
// constants and notes
//------------------------------------------------------------
package sink_fifo_pkg;
   localparam int WORD_W = 32;
   localparam int BYTES_W = 2;
   localparam int CHAN_W = 8;
   localparam int DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] FULL_WARN_THRESHOLD = 5'h0c;
   localparam logic [CNT_W-1:0] FIFO_CAPACITY = 5'h10;
   localparam logic [CNT_W-1:0] ONE_WORD = 5'h01;
   // flag positions inside a stored entry
   localparam int F_START = 0;
   localparam int F_END = 1;
   localparam int F_ABORT = 2;
   localparam int F_BURST = 3;
   localparam int F_SPAR = 4;
   localparam int F_EPAR = 5;
   localparam int F_ORPHAN = 6;
   localparam int FLAG_W = 7;
   localparam int BYTES_LSB = FLAG_W;
   localparam int CHAN_LSB = BYTES_LSB + BYTES_W;
   localparam int WORD_LSB = CHAN_LSB + CHAN_W;
   localparam int ENTRY_W = WORD_LSB + WORD_W;
   localparam int SKID_DEPTH = 2;
endpackage

// ### core/skid_pair.sv
`timescale 1ns/1ns
// two-entry buffer, valid/ready on both sides
module skid_pair #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   logic [WIDTH-1:0] slot0_q, slot1_q;
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic push, pop;

   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_valid_out = (cnt_q != 2'h0);
   assign out_data_out = slot0_q;

   // occupancy
   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 2'h1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         cnt_q <= 2'h0;
         in_ready_out <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         in_ready_out <= (cnt_d != 2'h2);
      end
   end

   // slot shifting: head in slot0
   always_ff @(posedge core_clk_in) begin
      if (pop) begin
         slot0_q <= (cnt_q == 2'h2) ? slot1_q : in_data_in;
         if (push && cnt_q == 2'h2) begin
            slot1_q <= in_data_in;
         end
      end else if (push) begin
         if (cnt_q == 2'h0) begin
            slot0_q <= in_data_in;
         end else begin
            slot1_q <= in_data_in;
         end
      end
   end
endmodule

// ### core/packet_sink_fifo_read_port.sv
`timescale 1ns/1ns
// receive fifo with its user read port
module packet_sink_fifo_read_port
   import sink_fifo_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // write side from the line receiver
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire logic [WORD_W-1:0] wr_word_in,
   input wire logic [CHAN_W-1:0] wr_channel_in,
   input wire logic [BYTES_W-1:0] wr_bytes_in,
   input wire logic wr_start_in,
   input wire logic wr_end_in,
   input wire logic wr_abort_in,
   input wire logic wr_burst_err_in,
   input wire logic wr_start_par_err_in,
   input wire logic wr_end_par_err_in,
   input wire logic wr_payload_ctrl_in,
   // user read port
   input wire logic read_request_n_in,
   output logic [WORD_W-1:0] read_word_out,
   output logic [CHAN_W-1:0] channel_number_out,
   output logic [BYTES_W-1:0] valid_byte_count_out,
   output logic fifo_start_flag_out,
   output logic fifo_end_flag_out,
   output logic fifo_abort_flag_out,
   output logic end_parity_error_out,
   output logic start_parity_error_out,
   output logic burst_termination_error_out,
   output logic orphan_data_error_out,
   output logic read_word_valid_out,
   output logic fifo_empty_n_out,
   output logic fifo_nearly_empty_n_out,
   output logic nearly_full_n_out,
   output logic fifo_overrun_n_out
);
   //------------------------------------------------------------
   // write side shaping
   //------------------------------------------------------------
   logic have_ctrl_q;
   logic orphan_w, closes_w;
   logic [ENTRY_W-1:0] entry_w, b_data;
   logic b_valid, b_ready, skid_ready;
   logic push_w, pop_w, overrun_q;
   logic [CNT_W-1:0] count_q, count_d;
   logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
   logic [ENTRY_W-1:0] mem [0:DEPTH-1];
   logic [ENTRY_W-1:0] head_w;

   // a word closes a packet or a burst
   assign closes_w = wr_end_in || wr_burst_err_in;
   // data with no payload control word in front
   assign orphan_w = !have_ctrl_q && !wr_payload_ctrl_in;

   // pack one entry; framing cleaned on the way in
   always_comb begin
      entry_w = '0;
      entry_w[WORD_LSB +: WORD_W] = wr_word_in;
      entry_w[CHAN_LSB +: CHAN_W] = wr_channel_in;
      entry_w[BYTES_LSB +: BYTES_W] = wr_bytes_in;
      entry_w[F_START] = wr_start_in;
      entry_w[F_END] = wr_end_in && !wr_burst_err_in;
      entry_w[F_ABORT] = wr_abort_in && wr_end_in && !wr_burst_err_in;
      entry_w[F_BURST] = wr_burst_err_in;
      entry_w[F_SPAR] = wr_start_par_err_in && closes_w;
      entry_w[F_EPAR] = wr_end_par_err_in && closes_w;
      entry_w[F_ORPHAN] = orphan_w;
   end

   // payload control tracking, held across the packet
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         have_ctrl_q <= 1'b0;
      end else if (wr_valid_in && wr_ready_out) begin
         have_ctrl_q <= (have_ctrl_q || wr_payload_ctrl_in) && !closes_w;
      end
   end

   // overrun: source wrote while refused
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         overrun_q <= 1'b0;
      end else if (wr_valid_in && !wr_ready_out) begin
         overrun_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         fifo_overrun_n_out <= 1'b1;
      end else begin
         fifo_overrun_n_out <= !(overrun_q || (wr_valid_in && !wr_ready_out));
      end
   end

   // skid buffer stalls the receiver; only after an overrun are its words dropped
   skid_pair #(.WIDTH(ENTRY_W)) u_skid (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .in_valid_in(wr_valid_in),
      .in_ready_out(skid_ready),
      .in_data_in(entry_w),
      .out_valid_out(b_valid),
      .out_ready_in(b_ready),
      .out_data_out(b_data)
   );
   assign wr_ready_out = skid_ready;

   //------------------------------------------------------------
   // storage
   //------------------------------------------------------------
   // in overrun the buffer drains into nothing
   assign b_ready = (count_q != FIFO_CAPACITY) || overrun_q;
   assign push_w = b_valid && (count_q != FIFO_CAPACITY) && !overrun_q;
   assign pop_w = !read_request_n_in && (count_q != '0);

   // occupancy after this edge
   always_comb begin
      count_d = count_q;
      if (push_w && !pop_w) begin
         count_d = count_q + ONE_WORD;
      end else if (pop_w && !push_w) begin
         count_d = count_q - ONE_WORD;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         count_q <= '0;
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         count_q <= count_d;
         if (push_w) begin
            wr_ptr_q <= wr_ptr_q + 4'h1;
         end
         if (pop_w) begin
            rd_ptr_q <= rd_ptr_q + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (push_w) begin
         mem[wr_ptr_q] <= b_data;
      end
   end

   // head entry, the one source of the popped word, channel, byte count and flags
   assign head_w = mem[rd_ptr_q];

   //------------------------------------------------------------
   // read port outputs
   //------------------------------------------------------------
   // popped word and its status, valid for one cycle
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         read_word_valid_out <= 1'b0;
         read_word_out <= '0;
         channel_number_out <= '0;
         valid_byte_count_out <= '0;
         fifo_start_flag_out <= 1'b0;
         fifo_end_flag_out <= 1'b0;
         fifo_abort_flag_out <= 1'b0;
         burst_termination_error_out <= 1'b0;
         start_parity_error_out <= 1'b0;
         end_parity_error_out <= 1'b0;
         orphan_data_error_out <= 1'b0;
      end else begin
         read_word_valid_out <= pop_w;
         if (pop_w) begin
            read_word_out <= head_w[WORD_LSB +: WORD_W];
            channel_number_out <= head_w[CHAN_LSB +: CHAN_W];
            valid_byte_count_out <= head_w[BYTES_LSB +: BYTES_W];
            fifo_start_flag_out <= head_w[F_START];
            fifo_end_flag_out <= head_w[F_END];
            fifo_abort_flag_out <= head_w[F_ABORT];
            burst_termination_error_out <= head_w[F_BURST];
            start_parity_error_out <= head_w[F_SPAR];
            end_parity_error_out <= head_w[F_EPAR];
            orphan_data_error_out <= head_w[F_ORPHAN];
         end else begin
            fifo_start_flag_out <= 1'b0;
            fifo_end_flag_out <= 1'b0;
            fifo_abort_flag_out <= 1'b0;
            burst_termination_error_out <= 1'b0;
            start_parity_error_out <= 1'b0;
            end_parity_error_out <= 1'b0;
            orphan_data_error_out <= 1'b0;
         end
      end
   end

   // level indications follow the new occupancy
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         fifo_empty_n_out <= 1'b0;
         fifo_nearly_empty_n_out <= 1'b0;
         nearly_full_n_out <= 1'b1;
      end else begin
         fifo_empty_n_out <= (count_d != '0);
         fifo_nearly_empty_n_out <= (count_d > ONE_WORD);
         nearly_full_n_out <= (count_d < FULL_WARN_THRESHOLD);
      end
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   sequence s_pop_req;
      !read_request_n_in && (count_q != '0);
   endsequence

   sequence s_last_pop;
      !read_request_n_in && (count_q == ONE_WORD) && !push_w;
   endsequence

   // source offers a word while the skid refuses it
   sequence s_overrun_write;
      wr_valid_in && !wr_ready_out;
   endsequence

   a_pop_gives_valid: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      s_pop_req |=> read_word_valid_out)
      else $error("popped word not marked valid");

   a_idle_no_valid: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      !pop_w |=> !read_word_valid_out && !fifo_end_flag_out && !fifo_start_flag_out)
      else $error("valid or framing without a pop");

   a_last_word_empty: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      s_last_pop |=> read_word_valid_out && !fifo_empty_n_out)
      else $error("empty not shown with last word");

   a_abort_with_end: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      fifo_abort_flag_out |-> fifo_end_flag_out && read_word_valid_out)
      else $error("abort without end");

   a_burst_no_end: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      burst_termination_error_out |-> !fifo_end_flag_out && !fifo_abort_flag_out)
      else $error("burst error with end or abort");

   a_parity_at_close: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      (end_parity_error_out || start_parity_error_out)
      |-> (fifo_end_flag_out || burst_termination_error_out))
      else $error("parity error off the last word");

   a_one_left: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      (count_q == ONE_WORD) == (!fifo_nearly_empty_n_out && fifo_empty_n_out))
      else $error("nearly empty level wrong");

   a_full_warning: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      (count_q >= FULL_WARN_THRESHOLD) |-> !nearly_full_n_out)
      else $error("nearly full missing at threshold");

   a_overrun_blocks: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      s_overrun_write |=> (!fifo_overrun_n_out && !push_w) [*2])
      else $error("writes after overrun");

   a_reset_state: assert property (
      @(posedge core_clk_in)
      sys_rst_in |=> !fifo_empty_n_out && !fifo_nearly_empty_n_out
      && !read_word_valid_out && nearly_full_n_out && fifo_overrun_n_out)
      else $error("bad state after reset");

   // level, overrun and status outputs checked against the occupancy and against each other
   a_empty_level: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      (count_q == '0) == !fifo_empty_n_out)
      else $error("empty level wrong");

   a_empty_no_pop: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      (count_q == '0) |=> !read_word_valid_out)
      else $error("word popped from an empty fifo");

   a_full_clear: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      (count_q < FULL_WARN_THRESHOLD) |-> nearly_full_n_out)
      else $error("nearly full below threshold");

   a_level_order: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      !nearly_full_n_out |-> fifo_nearly_empty_n_out)
      else $error("nearly full and nearly empty together");

   a_overrun_sticky: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      !fifo_overrun_n_out |=> !fifo_overrun_n_out)
      else $error("overrun released without reset");

   a_count_bound: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      count_q <= FIFO_CAPACITY)
      else $error("occupancy above capacity");

   a_flags_need_valid: assert property (
      @(posedge core_clk_in) disable iff (sys_rst_in)
      (fifo_start_flag_out || fifo_end_flag_out || burst_termination_error_out
      || start_parity_error_out || end_parity_error_out || orphan_data_error_out) |-> read_word_valid_out)
      else $error("status flag without valid");
endmodule

// ### verif/pop_reader.sv
`timescale 1ns/1ns
// user read logic on the far side of the read port
module pop_reader (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic pop_en_in,
   input wire logic fifo_empty_n_in,
   input wire logic fifo_nearly_empty_n_in,
   output logic read_request_n_out
);
   // request only while words are stored; after nearly empty pop once and stop
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         read_request_n_out <= 1'b1;
      end else begin
         read_request_n_out <= !(pop_en_in && fifo_empty_n_in
            && (fifo_nearly_empty_n_in || read_request_n_out));
      end
   end
endmodule

// ### verif/packet_sink_fifo_read_port_test.sv
`timescale 1ns/1ns
module packet_sink_fifo_read_port_test;
   import sink_fifo_pkg::*;
   //------------------------------------------------------------
   // stimulus, reference queue and counters
   //------------------------------------------------------------
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic wr_valid = 1'b0;
   logic [WORD_W-1:0] wr_word = '0;
   logic [CHAN_W-1:0] wr_chan = '0;
   logic [BYTES_W-1:0] wr_bytes = '0;
   logic wr_start = 1'b0;
   logic wr_end = 1'b0;
   logic wr_abort = 1'b0;
   logic wr_burst = 1'b0;
   logic wr_spar = 1'b0;
   logic wr_epar = 1'b0;
   logic wr_payload = 1'b0;
   logic pop_en = 1'b0;
   logic seen_ctrl = 1'b0;
   logic read_request_n;
   logic wr_ready_out, read_word_valid_out, fifo_empty_n_out, fifo_nearly_empty_n_out;
   logic nearly_full_n_out, fifo_overrun_n_out, fifo_start_flag_out, fifo_end_flag_out;
   logic fifo_abort_flag_out, end_parity_error_out, start_parity_error_out;
   logic burst_termination_error_out, orphan_data_error_out;
   logic [WORD_W-1:0] read_word_out;
   logic [CHAN_W-1:0] channel_number_out;
   logic [BYTES_W-1:0] valid_byte_count_out;
   logic [48:0] exp_q [$];
   int bad_count = 0;
   int tests_run = 0;

   // 100 MHz clock
   always #5 core_clk = ~core_clk;

   packet_sink_fifo_read_port packet_sink_fifo_read_port_i (
      .core_clk_in(core_clk), .sys_rst_in(sys_rst), .wr_valid_in(wr_valid), .wr_ready_out(wr_ready_out),
      .wr_word_in(wr_word), .wr_channel_in(wr_chan), .wr_bytes_in(wr_bytes), .wr_start_in(wr_start),
      .wr_end_in(wr_end), .wr_abort_in(wr_abort), .wr_burst_err_in(wr_burst),
      .wr_start_par_err_in(wr_spar), .wr_end_par_err_in(wr_epar), .wr_payload_ctrl_in(wr_payload),
      .read_request_n_in(read_request_n), .read_word_out(read_word_out),
      .channel_number_out(channel_number_out), .valid_byte_count_out(valid_byte_count_out),
      .fifo_start_flag_out(fifo_start_flag_out), .fifo_end_flag_out(fifo_end_flag_out),
      .fifo_abort_flag_out(fifo_abort_flag_out), .end_parity_error_out(end_parity_error_out),
      .start_parity_error_out(start_parity_error_out),
      .burst_termination_error_out(burst_termination_error_out),
      .orphan_data_error_out(orphan_data_error_out), .read_word_valid_out(read_word_valid_out),
      .fifo_empty_n_out(fifo_empty_n_out), .fifo_nearly_empty_n_out(fifo_nearly_empty_n_out),
      .nearly_full_n_out(nearly_full_n_out), .fifo_overrun_n_out(fifo_overrun_n_out));

   pop_reader pop_reader_i (
      .core_clk_in(core_clk), .sys_rst_in(sys_rst), .pop_en_in(pop_en), .fifo_empty_n_in(fifo_empty_n_out),
      .fifo_nearly_empty_n_in(fifo_nearly_empty_n_out), .read_request_n_out(read_request_n));

   //------------------------------------------------------------
   // shared tasks
   //------------------------------------------------------------
   task automatic cmp(input string what, input logic [48:0] exp, input logic [48:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // offer one word, hold it until taken, queue its expected read-side image
   task automatic push(input logic [6:0] f, input logic [7:0] ch);
      int n;
      logic endx, close;
      n = 0;
      {wr_payload, wr_epar, wr_spar, wr_burst, wr_abort, wr_end, wr_start} <= f;
      wr_word <= {ch, ~ch, ch, 8'h3c};
      wr_chan <= ch;
      wr_bytes <= ch[1:0];
      wr_valid <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (wr_ready_out !== 1'b1 && n < 50);
      if (n >= 50) cmp("write taken", 1'b1, wr_ready_out);
      seen_ctrl = seen_ctrl | f[6];
      endx = f[1] & !f[3];
      close = f[1] | f[3];
      exp_q.push_back({ch, ~ch, ch, 8'h3c, ch, ch[1:0], !seen_ctrl, f[5] & close, f[4] & close, f[3],
                       f[2] & endx, endx, f[0]});
      if (close) seen_ctrl = 1'b0;
   endtask

   task automatic settle(input int n);
      wr_valid <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask

   task automatic drain();
      int n;
      n = 0;
      pop_en <= 1'b1;
      while (exp_q.size() != 0 && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      cmp("words left", 0, exp_q.size());
      settle(4);
      pop_en <= 1'b0;
   endtask

   // every popped word against the reference, empty flags with the last one
   always @(posedge core_clk) begin
      if (!sys_rst && read_word_valid_out === 1'b1) begin
         if (exp_q.size() == 0) begin
            cmp("unexpected word", 1'b0, read_word_valid_out);
         end else begin
            cmp("popped word", exp_q.pop_front(), {read_word_out, channel_number_out, valid_byte_count_out,
                orphan_data_error_out, end_parity_error_out, start_parity_error_out,
                burst_termination_error_out, fifo_abort_flag_out, fifo_end_flag_out,
                fifo_start_flag_out});
            if (exp_q.size() == 0 && !wr_valid)
               cmp("empty with last", 2'b00, {fifo_empty_n_out, fifo_nearly_empty_n_out});
         end
      end
   end

   //------------------------------------------------------------
   // scenarios
   //------------------------------------------------------------
   task automatic t_reset();
      sys_rst <= 1'b1;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      exp_q.delete();
      seen_ctrl = 1'b0;
      settle(1);
      cmp("reset state", 6'h07, {fifo_empty_n_out, fifo_nearly_empty_n_out, read_word_valid_out,
          nearly_full_n_out, fifo_overrun_n_out, wr_ready_out});
      @(posedge core_clk);
      $display("test reset done");
   endtask

   task automatic t_frames();
      logic [6:0] codes [14] = '{7'h41, 7'h00, 7'h02, 7'h71, 7'h36, 7'h41, 7'h1e,
                                 7'h00, 7'h00, 7'h40, 7'h02, 7'h03, 7'h45, 7'h22};
      pop_en <= 1'b1;
      for (int i = 0; i < 14; i++) push(codes[i], 8'(8'h40 + i));
      settle(1);
      drain();
      @(posedge core_clk);
      $display("test frames done");
   endtask

   task automatic t_fill();
      pop_en <= 1'b0;
      for (int k = 1; k <= 16; k++) begin
         push(7'h00, 8'(k));
         settle(3);
         cmp("levels", {1'b1, k > 1, k < 12}, {fifo_empty_n_out, fifo_nearly_empty_n_out,
             nearly_full_n_out});
         @(posedge core_clk);
      end
      push(7'h00, 8'h11);
      push(7'h00, 8'h12);
      settle(3);
      cmp("ready when full", 1'b0, wr_ready_out);
      @(posedge core_clk);
      $display("test fill done");
   endtask

   task automatic t_overrun();
      wr_valid <= 1'b1;
      @(posedge core_clk);
      settle(2);
      cmp("overrun", 1'b0, fifo_overrun_n_out);
      // the two words parked in the skid buffer are dropped, never stored
      void'(exp_q.pop_back());
      void'(exp_q.pop_back());
      @(posedge core_clk);
      drain();
      @(posedge core_clk);
      wr_chan <= 8'h77;
      wr_valid <= 1'b1;
      @(posedge core_clk);
      settle(8);
      cmp("nothing stored", 2'b00, {fifo_empty_n_out, fifo_overrun_n_out});
      @(posedge core_clk);
      $display("test overrun done");
      t_reset();
   endtask

   // main sequence
   initial begin
      t_reset();
      t_frames();
      t_fill();
      t_overrun();
      conclude();
   end

   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #20000;
      bad_count++;
      conclude();
   end
endmodule
